// ===== core/csf_pkg.sv
// Purpose: Shared constants and carriers for the charger status and flag bank.
// Assumes: Byte-wide register port, one clock, synchronous active-high reset.
// Notes:   Offsets are the printed register addresses.
package csf_pkg;

  // Register offsets
  localparam logic [7:0] CSF_OFS_FAULT_STAT  = 8'h01;
  localparam logic [7:0] CSF_OFS_ALARM_STAT  = 8'h02;
  localparam logic [7:0] CSF_OFS_CHG_FLAGS   = 8'h03;
  localparam logic [7:0] CSF_OFS_FAULT_FLAGS = 8'h04;

  // Reset value of both flag bytes
  localparam logic [7:0] CSF_FLAG_RESET = 8'h00;

  // Fault status / fault flag bit positions
  localparam int CSF_B_OVP   = 7;
  localparam int CSF_B_OCP   = 5;
  localparam int CSF_B_UVLO  = 4;
  localparam int CSF_B_COLD  = 3;
  localparam int CSF_B_COOL  = 2;
  localparam int CSF_B_WARM  = 1;
  localparam int CSF_B_HOT   = 0;

  // Alarm status bit positions
  localparam int CSF_B_CMP1  = 6;
  localparam int CSF_B_CMP2  = 5;
  localparam int CSF_B_CMP3  = 4;
  localparam int CSF_B_OPEN  = 0;

  // Charger flag bit positions
  localparam int CSF_B_TAPER = 6;
  localparam int CSF_B_DONE  = 5;
  localparam int CSF_B_ILIM  = 4;
  localparam int CSF_B_PPATH = 3;
  localparam int CSF_B_VDPM  = 2;
  localparam int CSF_B_THERM = 1;
  localparam int CSF_B_PGOOD = 0;

  // Live conditions from the fault and thermistor circuits
  typedef struct packed {
    logic input_overvoltage_state;
    logic battery_overcurrent_state;
    logic battery_undervoltage_state;
    logic thermistor_cold_state;
    logic thermistor_cool_state;
    logic thermistor_warm_state;
    logic thermistor_hot_state;
  } csf_fault_s;

  // Live comparator and thermistor-open conditions
  typedef struct packed {
    logic comparator_one_alarm_state;
    logic comparator_two_alarm_state;
    logic comparator_three_alarm_state;
    logic thermistor_open_state;
  } csf_alarm_s;

  // Live charger regulation conditions
  typedef struct packed {
    logic taper_active;
    logic done_active;
    logic input_limit_active;
    logic powerpath_active;
    logic input_voltage_active;
    logic thermal_active;
  } csf_charger_s;

  // Register access request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csf_req_s;

endpackage : csf_pkg

// ===== core/csf_edge_det.sv
// Purpose: Rising-edge (or any-edge) detector for a vector of live levels.
// Assumes: Levels are synchronous to the clock.
// Notes:   First cycle after reset raises no edge; history loads quietly.
`timescale 1ns/1ps
module csf_edge_det
  import csf_pkg::*;
#(
  parameter int W   = 8,
  parameter bit ANY = 1'b0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Levels in, pulses out
  input  wire logic [W-1:0] lvl_i,
  output logic      [W-1:0] pulse_o
);

  logic [W-1:0] prev_r;
  logic         primed_r;

  // Remember last level so each transition becomes one pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_r   <= '0;
      primed_r <= 1'b0;
    end else begin
      prev_r   <= lvl_i;
      primed_r <= 1'b1;
    end
  end

  // Either direction or rising only
  assign pulse_o = !primed_r ? '0 : (ANY ? (lvl_i ^ prev_r) : (lvl_i & ~prev_r));

endmodule : csf_edge_det

// ===== core/csf_flag_byte.sv
// Purpose: One clear-on-read byte of sticky event flags.
// Assumes: Set pulses and read strobe are synchronous to the clock.
// Notes:   A set in the clearing cycle survives the clear.
`timescale 1ns/1ps
module csf_flag_byte
  import csf_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Events and clearing read
  input  wire logic [7:0] set_i,
  input  wire logic       clr_i,
  // Flag contents
  output logic      [7:0] flags_o
);

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;

  // Set beats clear so no event is lost across a read
  always_comb begin
    flags_nxt = (clr_i ? 8'h00 : flags_r) | set_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= CSF_FLAG_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags_o = flags_r;

endmodule : csf_flag_byte

// ===== core/csf_bank.sv
// Purpose: Charger status and event-flag register group, read by a host.
// Assumes: Register requests arrive as one-cycle rd/wr strobes with a byte address.
// Notes:   Read data is registered and valid the cycle after the read strobe.
//
// Summary of operation
// - Offset 0x1 reads live fault and thermistor status; read-only, no reset value.
// - Bit 7 of fault status shows input overvoltage active.
// - Bit 5 of fault status shows battery overcurrent protection active.
// - Bit 4 of fault status is 1 while battery is below lockout level.
// - Bit 3 of fault status shows thermistor cold region, charging suspended.
// - Bit 2 of fault status shows thermistor cool region, current reduced.
// - Bit 1 of fault status shows thermistor warm region, voltage reduced.
// - Bit 0 of fault status shows thermistor hot region; bit 6 reserved.
// - Offset 0x2 reads alarm and open status; bits 7 and 3..1 reserved.
// - Bits 6,5,4 of alarm status show comparators one, two, three met.
// - Charger event flags at offset 0x3, reset 0x0, cleared whole on read.
// - Charger flag bit 6 sets on entry to constant-voltage taper charging.
// - Charger flag bit 5 sets on charge termination.
// - Charger flag bit 4 sets on input current limiting.
// - Charger flag bit 3 sets on dynamic power-path management operation.
// - Charger flag bit 2 sets on input-voltage power management operation.
// - Charger flag bit 1 sets on thermal regulation; bit 7 reserved.
// - Charger flag bit 0 sets on any change of input power-good.
// - Fault event flags at offset 0x4, reset 0x0, cleared on read.
// - Power-good needs input above lockout, above battery plus offset, below overvoltage.
// - Fault flag bits 7,5..0 set on entry into the matching fault or region.
`timescale 1ns/1ps
module csf_bank
  import csf_pkg::*;
(
  // Clock and reset
  input  wire logic         MCLK_I,
  input  wire logic         RST_I,
  // Register access
  input  wire csf_req_s     REQ_I,
  output logic      [7:0]   RDATA_O,
  output logic              RVALID_O,
  // Live conditions from analog circuits
  input  wire csf_fault_s   FAULT_I,
  input  wire csf_alarm_s   ALARM_I,
  input  wire csf_charger_s CHARGER_I,
  // Input power-good comparator results
  input  wire logic         VIN_ABOVE_LOCKOUT_I,
  input  wire logic         VIN_ABOVE_BAT_SLEEP_I,
  input  wire logic         VIN_BELOW_OVERVOLTAGE_I,
  // Current power-good level
  output logic              PGOOD_O
);

  // Byte assembly shared by status and flag layouts
  function automatic logic [7:0] fault_byte(input csf_fault_s f);
    logic [7:0] b;
    b              = 8'h00;
    b[CSF_B_OVP]   = f.input_overvoltage_state;
    b[CSF_B_OCP]   = f.battery_overcurrent_state;
    b[CSF_B_UVLO]  = f.battery_undervoltage_state;
    b[CSF_B_COLD]  = f.thermistor_cold_state;
    b[CSF_B_COOL]  = f.thermistor_cool_state;
    b[CSF_B_WARM]  = f.thermistor_warm_state;
    b[CSF_B_HOT]   = f.thermistor_hot_state;
    return b;
  endfunction : fault_byte

  logic [7:0] fault_stat;
  logic [7:0] alarm_stat;
  logic [7:0] chg_lvl;
  logic [7:0] chg_rise;
  logic [7:0] pg_any;
  logic [7:0] fault_rise;
  logic [7:0] chg_set;
  logic [7:0] chg_flags;
  logic [7:0] fault_flags;
  logic       pgood;
  logic       rd_chg;
  logic       rd_fault;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic       rvalid_r;

  // Power-good is the conjunction of all three input windows
  assign pgood   = VIN_ABOVE_LOCKOUT_I & VIN_ABOVE_BAT_SLEEP_I
                 & VIN_BELOW_OVERVOLTAGE_I;
  assign PGOOD_O = pgood;

  // Live fault byte, reserved bit 6 forced low
  assign fault_stat = fault_byte(FAULT_I);

  // Live alarm byte, reserved bits read zero
  always_comb begin
    alarm_stat             = 8'h00;
    alarm_stat[CSF_B_CMP1] = ALARM_I.comparator_one_alarm_state;
    alarm_stat[CSF_B_CMP2] = ALARM_I.comparator_two_alarm_state;
    alarm_stat[CSF_B_CMP3] = ALARM_I.comparator_three_alarm_state;
    alarm_stat[CSF_B_OPEN] = ALARM_I.thermistor_open_state;
  end

  // Charger regulation levels lined up with their flag bits
  always_comb begin
    chg_lvl              = 8'h00;
    chg_lvl[CSF_B_TAPER] = CHARGER_I.taper_active;
    chg_lvl[CSF_B_DONE]  = CHARGER_I.done_active;
    chg_lvl[CSF_B_ILIM]  = CHARGER_I.input_limit_active;
    chg_lvl[CSF_B_PPATH] = CHARGER_I.powerpath_active;
    chg_lvl[CSF_B_VDPM]  = CHARGER_I.input_voltage_active;
    chg_lvl[CSF_B_THERM] = CHARGER_I.thermal_active;
  end

  // Regulation entries are rising edges of the live levels
  csf_edge_det #(
    .W   (8),
    .ANY (1'b0)
  ) u_chg_edge (
    .clk_i   (MCLK_I),
    .rst_i   (RST_I),
    .lvl_i   (chg_lvl),
    .pulse_o (chg_rise)
  );

  // Power-good flags on both directions of change
  csf_edge_det #(
    .W   (8),
    .ANY (1'b1)
  ) u_pg_edge (
    .clk_i   (MCLK_I),
    .rst_i   (RST_I),
    .lvl_i   ({7'h00, pgood}),
    .pulse_o (pg_any)
  );

  // Fault and region entries
  csf_edge_det #(
    .W   (8),
    .ANY (1'b0)
  ) u_fault_edge (
    .clk_i   (MCLK_I),
    .rst_i   (RST_I),
    .lvl_i   (fault_stat),
    .pulse_o (fault_rise)
  );

  // Merge the power-good change into bit 0; bit 7 stays reserved
  always_comb begin
    chg_set              = chg_rise;
    chg_set[7]           = 1'b0;
    chg_set[CSF_B_PGOOD] = pg_any[0];
  end

  // Clearing reads; writes never reach the flag bytes
  assign rd_chg   = REQ_I.rd && (REQ_I.addr == CSF_OFS_CHG_FLAGS);
  assign rd_fault = REQ_I.rd && (REQ_I.addr == CSF_OFS_FAULT_FLAGS);

  csf_flag_byte u_chg_flags (
    .clk_i   (MCLK_I),
    .rst_i   (RST_I),
    .set_i   (chg_set),
    .clr_i   (rd_chg),
    .flags_o (chg_flags)
  );

  csf_flag_byte u_fault_flags (
    .clk_i   (MCLK_I),
    .rst_i   (RST_I),
    .set_i   (fault_rise),
    .clr_i   (rd_fault),
    .flags_o (fault_flags)
  );

  // Read mux; the flag value returned is the one present before the clear
  always_comb begin
    case (REQ_I.addr)
      CSF_OFS_FAULT_STAT:  rdata_nxt = fault_stat;
      CSF_OFS_ALARM_STAT:  rdata_nxt = alarm_stat;
      CSF_OFS_CHG_FLAGS:   rdata_nxt = chg_flags;
      CSF_OFS_FAULT_FLAGS: rdata_nxt = fault_flags;
      default:             rdata_nxt = 8'h00;
    endcase
  end

  // Registered read data; held between reads
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rdata_r <= 8'h00;
    end else if (REQ_I.rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  // One-cycle answer strobe
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= REQ_I.rd;
    end
  end

  assign RDATA_O  = rdata_r;
  assign RVALID_O = rvalid_r;

  // Assertions
  sequence pg_toggle_s;
    !RST_I && !$past(RST_I) && $changed(pgood);
  endsequence

  sequence chg_read_s;
    rd_chg && !(|chg_set);
  endsequence

  sequence fault_stat_rd_s;
    REQ_I.rd && REQ_I.addr == CSF_OFS_FAULT_STAT;
  endsequence

  sequence alarm_stat_rd_s;
    REQ_I.rd && REQ_I.addr == CSF_OFS_ALARM_STAT;
  endsequence

  pgood_formula_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    PGOOD_O == (VIN_ABOVE_LOCKOUT_I && VIN_ABOVE_BAT_SLEEP_I && VIN_BELOW_OVERVOLTAGE_I))
    else $error("power-good level wrong");

  pg_change_flag_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    pg_toggle_s |=> chg_flags[CSF_B_PGOOD])
    else $error("power-good change not flagged");

  chg_clear_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    chg_read_s |=> chg_flags == 8'h00)
    else $error("charger flags not cleared by read");

  fault_clear_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    rd_fault && !(|fault_rise) |=> fault_flags == 8'h00)
    else $error("fault flags not cleared by read");

  set_beats_clear_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    rd_chg && chg_set[CSF_B_TAPER] |=> chg_flags[CSF_B_TAPER])
    else $error("taper event lost in clearing read");

  flag_sticky_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    fault_flags[CSF_B_COLD] && !rd_fault |=> fault_flags[CSF_B_COLD])
    else $error("fault flag dropped without read");

  write_no_effect_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    REQ_I.wr && !REQ_I.rd && !(|chg_set) |=> chg_flags == $past(chg_flags))
    else $error("write altered charger flags");

  ovp_entry_flag_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    fault_rise[CSF_B_OVP] |=> fault_flags[CSF_B_OVP])
    else $error("overvoltage entry not flagged");

  status_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    REQ_I.rd && REQ_I.addr == CSF_OFS_FAULT_STAT |=> RVALID_O && RDATA_O == $past(fault_stat))
    else $error("fault status read mismatch");

  alarm_reserved_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    REQ_I.rd && REQ_I.addr == CSF_OFS_ALARM_STAT |=> (RDATA_O & 8'h8e) == 8'h00)
    else $error("alarm reserved bits not zero");

  cmp_one_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    REQ_I.rd && REQ_I.addr == CSF_OFS_ALARM_STAT
      |=> RDATA_O[CSF_B_CMP1] == $past(ALARM_I.comparator_one_alarm_state))
    else $error("comparator one bit mismatch");

  taper_entry_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !RST_I && !$past(RST_I) && $rose(CHARGER_I.taper_active) |=> chg_flags[CSF_B_TAPER])
    else $error("taper entry not flagged");

  // Strobe and hold checks, then bit checks against the live pins, so a swapped field cannot hide
  rvalid_rise_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    REQ_I.rd |=> RVALID_O)
    else $error("read not answered");

  rvalid_fall_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !REQ_I.rd |=> !RVALID_O)
    else $error("answer strobe without read");

  rdata_hold_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !REQ_I.rd |=> $stable(RDATA_O))
    else $error("read data moved without read");

  ovp_stat_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    fault_stat_rd_s |=> RDATA_O[CSF_B_OVP] == $past(FAULT_I.input_overvoltage_state))
    else $error("overvoltage status bit mismatch");

  ocp_stat_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    fault_stat_rd_s |=> RDATA_O[CSF_B_OCP] == $past(FAULT_I.battery_overcurrent_state))
    else $error("overcurrent status bit mismatch");

  uvlo_stat_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    fault_stat_rd_s |=> RDATA_O[CSF_B_UVLO] == $past(FAULT_I.battery_undervoltage_state))
    else $error("undervoltage status bit mismatch");

  cold_stat_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    fault_stat_rd_s |=> RDATA_O[CSF_B_COLD] == $past(FAULT_I.thermistor_cold_state))
    else $error("cold status bit mismatch");

  cool_stat_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    fault_stat_rd_s |=> RDATA_O[CSF_B_COOL] == $past(FAULT_I.thermistor_cool_state))
    else $error("cool status bit mismatch");

  warm_stat_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    fault_stat_rd_s |=> RDATA_O[CSF_B_WARM] == $past(FAULT_I.thermistor_warm_state))
    else $error("warm status bit mismatch");

  hot_stat_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    fault_stat_rd_s |=> RDATA_O[CSF_B_HOT] == $past(FAULT_I.thermistor_hot_state))
    else $error("hot status bit mismatch");

  fault_reserved_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    fault_stat_rd_s |=> !RDATA_O[6])
    else $error("fault status reserved bit set");

  cmp_two_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    alarm_stat_rd_s |=> RDATA_O[CSF_B_CMP2] == $past(ALARM_I.comparator_two_alarm_state))
    else $error("comparator two bit mismatch");

  cmp_three_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    alarm_stat_rd_s |=> RDATA_O[CSF_B_CMP3] == $past(ALARM_I.comparator_three_alarm_state))
    else $error("comparator three bit mismatch");

  open_stat_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    alarm_stat_rd_s |=> RDATA_O[CSF_B_OPEN] == $past(ALARM_I.thermistor_open_state))
    else $error("thermistor open bit mismatch");

  done_entry_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !$past(RST_I) && $rose(CHARGER_I.done_active) |=> chg_flags[CSF_B_DONE])
    else $error("termination not flagged");

  ilim_entry_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !$past(RST_I) && $rose(CHARGER_I.input_limit_active) |=> chg_flags[CSF_B_ILIM])
    else $error("input limiting not flagged");

  ppath_entry_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !$past(RST_I) && $rose(CHARGER_I.powerpath_active) |=> chg_flags[CSF_B_PPATH])
    else $error("power-path management not flagged");

  vdpm_entry_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !$past(RST_I) && $rose(CHARGER_I.input_voltage_active) |=> chg_flags[CSF_B_VDPM])
    else $error("input-voltage management not flagged");

  therm_entry_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !$past(RST_I) && $rose(CHARGER_I.thermal_active) |=> chg_flags[CSF_B_THERM])
    else $error("thermal regulation not flagged");

  chg_reserved_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !chg_flags[7])
    else $error("charger flag reserved bit set");

  cold_entry_flag_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !$past(RST_I) && $rose(FAULT_I.thermistor_cold_state) |=> fault_flags[CSF_B_COLD])
    else $error("cold entry not flagged");

  chg_sticky_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    chg_flags[CSF_B_DONE] && !rd_chg |=> chg_flags[CSF_B_DONE])
    else $error("charger flag dropped without read");

endmodule : csf_bank

// ===== testbench/csf_host.sv
// Purpose: Host model that reads and writes the flag bank one byte at a time.
// Assumes: Requests change on the falling edge; read data arrives one cycle later.
// Notes:   Idle address and data are inverted so stale values never look valid.
`timescale 1ns/1ps
module csf_host
  import csf_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Request out, answer in
  output csf_req_s        req_o,
  input  wire logic       rvalid_i,
  input  wire logic [7:0] rdata_i
);
  // Idle bus at time zero
  initial req_o = '{rd: 1'b0, wr: 1'b0, addr: 8'h5a, wdata: 8'ha5};

  // One read: strobe for one edge, take the answer in the next cycle
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk_i);
    req_o.rd   = 1'b1;
    req_o.addr = a;
    @(negedge clk_i);
    ok         = rvalid_i;
    d          = rdata_i;
    req_o.rd   = 1'b0;
    req_o.addr = ~a;
  endtask : read_reg

  // One write: strobe for one edge, then scramble the released fields
  task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_i);
    req_o.wr    = 1'b1;
    req_o.addr  = a;
    req_o.wdata = v;
    @(negedge clk_i);
    req_o.wr    = 1'b0;
    req_o.addr  = ~a;
    req_o.wdata = ~v;
  endtask : write_reg
endmodule : csf_host

// ===== testbench/csf_bank_tb.sv
// Purpose: Self-checking bench for the charger status and flag bank.
// Assumes: Inputs change on the falling edge; reset held for 8 cycles.
// Notes:   Expected bytes are built from bit positions, never from the design.
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module csf_bank_tb;
  import csf_pkg::*;
  logic         MCLK_I;
  logic         RST_I;
  csf_req_s     req;
  logic [7:0]   rdata;
  logic         rvalid;
  csf_fault_s   fault;
  csf_alarm_s   alarm;
  csf_charger_s chg;
  logic [2:0]   vin;
  logic         pgood;
  int           fails;
  int           comparisons;
  int           cycles;

  csf_bank dut_u (.MCLK_I(MCLK_I), .RST_I(RST_I), .REQ_I(req), .RDATA_O(rdata),
    .RVALID_O(rvalid), .FAULT_I(fault), .ALARM_I(alarm), .CHARGER_I(chg),
    .VIN_ABOVE_LOCKOUT_I(vin[0]), .VIN_ABOVE_BAT_SLEEP_I(vin[1]),
    .VIN_BELOW_OVERVOLTAGE_I(vin[2]), .PGOOD_O(pgood));

  csf_host host_u (.clk_i(MCLK_I), .req_o(req), .rvalid_i(rvalid), .rdata_i(rdata));

  // Free-running 20 MHz clock
  initial begin
    MCLK_I = 1'b0;
    forever #25 MCLK_I = ~MCLK_I;
  end

  // Hang guard: far above the fewer than 200 cycles the tests need
  always @(posedge MCLK_I) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish();
    end
  end

  // Print the counts and the verdict, then stop
  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Read one byte and compare it, also checking the valid pulse
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host_u.read_reg(a, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, exp)
  endtask : rd_chk

  // Flag bytes clear after reset; unmapped offset reads zero
  task automatic t_reset;
    rd_chk(CSF_OFS_CHG_FLAGS, CSF_FLAG_RESET);   // Charger flags
    rd_chk(CSF_OFS_FAULT_FLAGS, CSF_FLAG_RESET); // Fault flags
    rd_chk(8'h00, 8'h00);                        // Unmapped offset
  endtask : t_reset

  // Walk each fault level: live bit, entry flag, then cleared by the read
  task automatic t_fault;
    logic [7:0] exp;
    for (int i = 0; i < 7; i++) begin
      @(negedge MCLK_I);
      fault = 7'(1 << i);
      exp   = 8'h01 << ((i == 6) ? 7 : i);
      rd_chk(CSF_OFS_FAULT_STAT, exp);  // Live bit
      rd_chk(CSF_OFS_FAULT_FLAGS, exp); // Entry latched
      rd_chk(CSF_OFS_FAULT_FLAGS, 8'h00); // Cleared by read
    end
    @(negedge MCLK_I);
    fault = '0;
    rd_chk(CSF_OFS_FAULT_FLAGS, 8'h00); // Leaving a region sets nothing
    rd_chk(CSF_OFS_FAULT_STAT, 8'h00);  // Live byte follows
  endtask : t_fault

  // Walk each alarm level; reserved bits stay low
  task automatic t_alarm;
    for (int i = 0; i < 4; i++) begin
      @(negedge MCLK_I);
      alarm = 4'(1 << i);
      rd_chk(CSF_OFS_ALARM_STAT, (i == 0) ? 8'h01 : 8'h01 << (i + 3));
    end
    @(negedge MCLK_I);
    alarm = '0;
    rd_chk(CSF_OFS_ALARM_STAT, 8'h00); // All clear
  endtask : t_alarm

  // Walk each charger level; a write between sets and read changes nothing
  task automatic t_charger;
    logic [7:0] exp;
    for (int i = 0; i < 6; i++) begin
      @(negedge MCLK_I);
      chg = 6'(1 << i);
      exp = 8'h02 << i;
      host_u.write_reg(CSF_OFS_CHG_FLAGS, 8'h00);
      rd_chk(CSF_OFS_CHG_FLAGS, exp);
      rd_chk(CSF_OFS_CHG_FLAGS, 8'h00); // Whole byte cleared
    end
    @(negedge MCLK_I);
    chg = '0;
    rd_chk(CSF_OFS_CHG_FLAGS, 8'h00); // Falling levels set nothing
  endtask : t_charger

  // Power-good needs all three comparators; either change sets bit 0
  task automatic t_pgood;
    @(negedge MCLK_I);
    vin = 3'b111;
    #1 `CHK(pgood, 1'b1)              // All three met
    rd_chk(CSF_OFS_CHG_FLAGS, 8'h01); // Becomes good
    for (int k = 0; k < 3; k++) begin
      @(negedge MCLK_I);
      vin[k] = 1'b0;
      #1 `CHK(pgood, 1'b0)              // One missing
      rd_chk(CSF_OFS_CHG_FLAGS, 8'h01); // Goes bad
      @(negedge MCLK_I);
      vin[k] = 1'b1;
      rd_chk(CSF_OFS_CHG_FLAGS, 8'h01); // Good again
    end
  endtask : t_pgood

  // Event arriving in the clearing read cycle must survive the clear
  task automatic t_set_wins;
    logic [7:0] d;
    logic       ok;
    fork
      host_u.read_reg(CSF_OFS_CHG_FLAGS, d, ok);
      begin
        @(negedge MCLK_I);
        chg = 6'h20;
      end
    join
    `CHK(ok, 1'b1)                    // Answer strobe seen
    `CHK(d, 8'h00)                    // Read shows byte before the event
    rd_chk(CSF_OFS_CHG_FLAGS, 8'h40); // Event kept
  endtask : t_set_wins

  // Writes to status and flag offsets leave a pending flag and live bits alone
  task automatic t_writes;
    @(negedge MCLK_I);
    fault = 7'h40;
    host_u.write_reg(CSF_OFS_FAULT_FLAGS, 8'h00);
    host_u.write_reg(CSF_OFS_FAULT_STAT, 8'hff);
    rd_chk(CSF_OFS_FAULT_STAT, 8'h80);  // Live byte unchanged
    rd_chk(CSF_OFS_FAULT_FLAGS, 8'h80); // Flag still pending
    @(negedge MCLK_I);
    fault = '0;
  endtask : t_writes

  // Main sequence
  initial begin
    RST_I = 1'b1;
    fault = '0;
    alarm = '0;
    chg   = '0;
    vin   = 3'b000;
    fails = 0;
    comparisons = 0;
    cycles = 0;
    repeat (8) @(negedge MCLK_I);
    RST_I = 1'b0;
    repeat (3) @(negedge MCLK_I);
    t_reset();
    t_fault();
    t_alarm();
    t_charger();
    t_pgood();
    t_set_wins();
    t_writes();
    tally_and_finish();
  end
endmodule : csf_bank_tb
